// ===== hw/fls_pkg.sv
// Shared constants for the fork level switch decision logic.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package fls_pkg;
   // Clock rate in hertz
   localparam int CLK_HZ = 200_000_000;
   // Settle time towards covered, in milliseconds
   localparam int COVER_DELAY_MS = 500;
   // Settle time towards free, in milliseconds
   localparam int FREE_DELAY_MS = 1000;
   // Fault flash rate in hertz
   localparam int FLASH_HZ = 2;
   // Frequency measurement window, in microseconds
   localparam int WINDOW_US = 10_000;
   // Derived cycle counts
   localparam int COVER_CYC = (CLK_HZ / 1000) * COVER_DELAY_MS;
   localparam int FREE_CYC = (CLK_HZ / 1000) * FREE_DELAY_MS;
   localparam int FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);
   localparam int WINDOW_CYC = (CLK_HZ / 1_000_000) * WINDOW_US;
   // Edges per window below which the fork counts as covered
   localparam int COVER_THRESH = 60;
   // Width of the timing counters
   localparam int CNT_W = 28;
   // Width of the edge counter
   localparam int EDGE_W = 16;
   // Slave address width and reset value
   localparam int ADDR_W = 5;
   localparam logic [4:0] ADDR_RESET = 5'h00;
   // Data nibble field positions
   localparam int COVERED_POS = 0;
   localparam int HEALTH_POS = 1;
   localparam int UNUSED_A_POS = 2;
   localparam int UNUSED_B_POS = 3;
   // Product variant straps
   typedef enum logic [1:0]
   {
      FLS_VAR_ANGLE = 2'h0,
      FLS_VAR_MICRO = 2'h1,
      FLS_VAR_BUS = 2'h3
   } fls_variant_t;
   // Settling states, Gray coded along the loop
   typedef enum logic [1:0]
   {
      FLS_ST_FREE = 2'h0,
      FLS_ST_TO_COV = 2'h1,
      FLS_ST_COVERED = 2'h3,
      FLS_ST_TO_FREE = 2'h2
   } fls_state_t;
endpackage : fls_pkg

// ===== hw/fls_top.sv
// Decision and output logic of a vibrating-fork level limit switch.
// Assumes fork, magnet, fault and strap inputs are asynchronous pins;
// bus address, error and parameter inputs come from same-clock logic.
`timescale 1ns/10ps
module fls_top #(
   // Settle count towards covered
   parameter logic [27:0] COVER_CNT = 28'(fls_pkg::COVER_CYC),
   // Settle count towards free
   parameter logic [27:0] FREE_CNT = 28'(fls_pkg::FREE_CYC),
   // Half period of the fault flash
   parameter logic [27:0] FLASH_CNT = 28'(fls_pkg::FLASH_HALF_CYC),
   // Measurement window length
   parameter logic [27:0] WINDOW_CNT = 28'(fls_pkg::WINDOW_CYC)
)
(
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Fork and test pins
   input wire logic i_fork_osc,
   input wire logic i_magnet,
   input wire logic i_load_fault,
   input wire logic i_sensor_fault,
   // Straps
   input wire logic i_mode_dry,
   input wire logic [1:0] i_variant,
   // Field bus side
   input wire logic i_addr_wr,
   input wire logic [4:0] i_addr_val,
   input wire logic i_comm_err,
   input wire logic [3:0] i_param_nibble,
   // Switch outputs, high means closed
   output logic o_switch_no,
   output logic o_switch_nc,
   // Indicators
   output logic o_led_green,
   output logic o_led_red,
   output logic o_led_yellow,
   // Bus data
   output logic [3:0] o_data_nibble,
   output logic [4:0] o_slave_addr
);

   // Whole module state
   typedef struct packed {
      logic [2:0] fork_sy;      // Fork sync pair plus edge history
      logic [1:0] mag_sy;       // Magnet sync pair
      logic [1:0] load_sy;      // Load fault sync pair
      logic [1:0] sens_sy;      // Sensor fault sync pair
      logic [5:0] strap_sy;     // Mode and variant sync pairs
      logic [27:0] win_cnt;     // Window up counter
      logic [15:0] edge_cnt;    // Edges in current window
      logic raw_cov;            // Unsettled classification
      fls_pkg::fls_state_t st;  // Settling state
      logic [27:0] deb_cnt;     // Settling counter
      logic covered;            // Settled classification
      logic [27:0] fl_cnt;      // Flash counter
      logic flash;              // Flash phase
      logic [4:0] addr;         // Slave address
      logic sw_no;              // Normally open switch
      logic sw_nc;              // Normally closed switch
      logic green;              // Power indicator
      logic red;                // State or fault indicator
      logic yellow;             // Covered indicator
      logic [3:0] data;         // Input data nibble
   } fls_regs_t;

   fls_regs_t st;
   fls_regs_t next_st;

   // Counter end test, shared by all timers
   function automatic logic hit(input logic [27:0] cnt, input logic [27:0] lim);
      hit = (cnt >= lim - 28'h0000001);
   endfunction : hit

   // Synced view of inputs, second stage only
   logic fork_now;
   logic mag;
   logic load_f;
   logic sens_f;
   logic mode_dry;
   logic [1:0] variant;
   logic fault;
   logic limit_sw;
   assign fork_now = st.fork_sy[1];
   assign mag = st.mag_sy[1];
   assign load_f = st.load_sy[1];
   assign sens_f = st.sens_sy[1];
   assign mode_dry = st.strap_sy[1];
   assign variant = {st.strap_sy[5], st.strap_sy[3]};
   // Any fault that must open the switches
   assign fault = load_f | sens_f;
   // Closed state before test and fault handling
   assign limit_sw = mode_dry ? st.covered : !st.covered;

   // Next state
   always_comb
   begin
      next_st = st;
      // Two-flop synchronisers, fork keeps one extra stage for edges
      next_st.fork_sy = {st.fork_sy[1:0], i_fork_osc};
      next_st.mag_sy = {st.mag_sy[0], i_magnet};
      next_st.load_sy = {st.load_sy[0], i_load_fault};
      next_st.sens_sy = {st.sens_sy[0], i_sensor_fault};
      next_st.strap_sy = {st.strap_sy[4], i_variant[1], st.strap_sy[2], i_variant[0],
                          st.strap_sy[0], i_mode_dry};
      // Count fork rising edges per window
      if (hit(st.win_cnt, WINDOW_CNT))
      begin
         // Low frequency means liquid on the fork
         next_st.raw_cov = (st.edge_cnt < 16'(fls_pkg::COVER_THRESH));
         next_st.win_cnt = 28'h0000000;
         next_st.edge_cnt = 16'h0000;
      end
      else
      begin
         // Window still open
         next_st.win_cnt = st.win_cnt + 28'h0000001;
         if (st.fork_sy[1] && !st.fork_sy[2] && st.edge_cnt != 16'hFFFF)
         begin
            next_st.edge_cnt = st.edge_cnt + 16'h0001;
         end
      end
      // Settling of the classification
      next_st.deb_cnt = st.deb_cnt + 28'h0000001;
      case (st.st)
         fls_pkg::FLS_ST_FREE:
         begin
            // Waiting for liquid
            next_st.deb_cnt = 28'h0000000;
            if (st.raw_cov)
            begin
               next_st.st = fls_pkg::FLS_ST_TO_COV;
            end
         end
         fls_pkg::FLS_ST_TO_COV:
         begin
            // Liquid must persist for the cover time
            if (!st.raw_cov)
            begin
               next_st.st = fls_pkg::FLS_ST_FREE;
            end
            else if (hit(st.deb_cnt, COVER_CNT))
            begin
               next_st.st = fls_pkg::FLS_ST_COVERED;
               next_st.covered = 1'b1;
            end
         end
         fls_pkg::FLS_ST_COVERED:
         begin
            // Waiting for the fork to clear
            next_st.deb_cnt = 28'h0000000;
            if (!st.raw_cov)
            begin
               next_st.st = fls_pkg::FLS_ST_TO_FREE;
            end
         end
         fls_pkg::FLS_ST_TO_FREE:
         begin
            // Air must persist for the free time
            if (st.raw_cov)
            begin
               next_st.st = fls_pkg::FLS_ST_COVERED;
            end
            else if (hit(st.deb_cnt, FREE_CNT))
            begin
               next_st.st = fls_pkg::FLS_ST_FREE;
               next_st.covered = 1'b0;
            end
         end
         default:
         begin
            // Unknown code falls back to free
            next_st.st = fls_pkg::FLS_ST_FREE;
            next_st.covered = 1'b0;
         end
      endcase
      // Flash phase generator
      if (hit(st.fl_cnt, FLASH_CNT))
      begin
         next_st.fl_cnt = 28'h0000000;
         next_st.flash = !st.flash;
      end
      else
      begin
         next_st.fl_cnt = st.fl_cnt + 28'h0000001;
      end
      // Address written by master or programmer
      if (i_addr_wr)
      begin
         next_st.addr = i_addr_val;
      end
      // Switches: magnet inverts, fault opens both
      if (fault || variant == fls_pkg::FLS_VAR_BUS)
      begin
         next_st.sw_no = 1'b0;
         next_st.sw_nc = 1'b0;
      end
      else
      begin
         // Complementary pair in normal operation
         next_st.sw_no = limit_sw ^ mag;
         next_st.sw_nc = !(limit_sw ^ mag);
      end
      // Powered means green lit
      next_st.green = 1'b1;
      // Covered indicator on micro connector variants
      next_st.yellow = (variant != fls_pkg::FLS_VAR_ANGLE) && st.covered;
      // Red indicator per variant
      if (sens_f)
      begin
         // Internal fault flashes on every variant
         next_st.red = st.flash;
      end
      else if (variant == fls_pkg::FLS_VAR_ANGLE)
      begin
         // Load fault flashes, else limit state shows
         next_st.red = load_f ? st.flash : (mode_dry ? !st.covered : st.covered);
      end
      else if (variant == fls_pkg::FLS_VAR_MICRO)
      begin
         // Load fault steady
         next_st.red = load_f;
      end
      else
      begin
         // Bus address zero or link error steady
         next_st.red = (st.addr == fls_pkg::ADDR_RESET) || i_comm_err;
      end
      // Data nibble, parameter input has no path here
      next_st.data = 4'h0;
      next_st.data[fls_pkg::COVERED_POS] = st.covered ^ mag;
      next_st.data[fls_pkg::HEALTH_POS] = !sens_f;
   end

   // State register
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         // Everything off, address zero
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign o_switch_no = st.sw_no;
   assign o_switch_nc = st.sw_nc;
   assign o_led_green = st.green;
   assign o_led_red = st.red;
   assign o_led_yellow = st.yellow;
   assign o_data_nibble = st.data;
   assign o_slave_addr = st.addr;

   // Checks; switch, sensor, angle, bus data and raw class antecedents also ask for reset low at their
   // own edge, so the edge that releases reset never judges those against flops still at reset values
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   // Switch checks
   a_fault_opens: assert property (!i_rst && fault |=> !o_switch_no && !o_switch_nc)
      else $error("switch closed during fault");
   a_dual_opposite: assert property (!i_rst && !fault && variant != fls_pkg::FLS_VAR_BUS
      |=> o_switch_no != o_switch_nc)
      else $error("outputs not complementary");
   a_overspill_mode: assert property (!i_rst && !fault && !mag && !mode_dry
      && variant != fls_pkg::FLS_VAR_BUS |=> o_switch_no == !$past(st.covered))
      else $error("overspill switch wrong");
   a_dryrun_mode: assert property (!i_rst && !fault && !mag && mode_dry
      && variant != fls_pkg::FLS_VAR_BUS |=> o_switch_no == $past(st.covered))
      else $error("dry-run switch wrong");
   a_magnet_flip: assert property (!i_rst && !fault && mag && variant != fls_pkg::FLS_VAR_BUS
      |=> o_switch_no == ($past(mode_dry) ^ $past(st.covered)))
      else $error("magnet did not invert switch");

   // Indicator checks
   a_green_lit: assert property ($past(!i_rst) |-> o_led_green)
      else $error("green off while powered");
   a_sens_flash: assert property (!i_rst && sens_f |=> o_led_red == $past(st.flash))
      else $error("sensor fault red not flashing");
   a_flash_period: assert property ($changed(st.flash) |-> $past(st.fl_cnt) == FLASH_CNT - 28'h0000001)
      else $error("flash half period wrong");
   a_angle_red: assert property (!i_rst && variant == fls_pkg::FLS_VAR_ANGLE && !sens_f && !load_f
      |=> o_led_red == ($past(mode_dry) ^ $past(st.covered)))
      else $error("angle red not limit state");
   a_angle_load: assert property (!i_rst && variant == fls_pkg::FLS_VAR_ANGLE && !sens_f && load_f
      |=> o_led_red == $past(st.flash))
      else $error("angle load fault red not flashing");
   a_load_steady: assert property (variant == fls_pkg::FLS_VAR_MICRO && !sens_f && load_f
      ##1 variant == fls_pkg::FLS_VAR_MICRO |-> o_led_red)
      else $error("micro load fault not steady");
   a_yellow_cov: assert property (variant != fls_pkg::FLS_VAR_ANGLE |=> o_led_yellow == $past(st.covered))
      else $error("yellow wrong");
   a_bus_addr_red: assert property (variant == fls_pkg::FLS_VAR_BUS && !sens_f
      && st.addr == fls_pkg::ADDR_RESET |=> o_led_red)
      else $error("red off at address zero");

   // Bus data checks
   a_addr_write: assert property (!i_rst && i_addr_wr |=> o_slave_addr == $past(i_addr_val))
      else $error("slave address not written");
   a_data_bits: assert property (!i_rst |=> o_data_nibble[0] == ($past(st.covered) ^ $past(mag))
      && o_data_nibble[1] == !$past(sens_f) && o_data_nibble[3:2] == 2'h0)
      else $error("data nibble wrong");

   // Classification and settling checks
   a_raw_class: assert property (!i_rst && st.win_cnt == WINDOW_CNT - 28'h0000001
      |=> st.raw_cov == ($past(st.edge_cnt) < 16'(fls_pkg::COVER_THRESH)))
      else $error("raw classification wrong");
   a_cover_settle: assert property ($rose(st.covered) |-> $past(st.st) == fls_pkg::FLS_ST_TO_COV
      && $past(st.deb_cnt) == COVER_CNT - 28'h0000001)
      else $error("covered without full settle");
   a_free_settle: assert property ($fell(st.covered) |-> $past(st.st) == fls_pkg::FLS_ST_TO_FREE
      && $past(st.deb_cnt) == FREE_CNT - 28'h0000001)
      else $error("free without full settle");

endmodule : fls_top

// ===== testbench/fls_fork_load_model.sv
// Model of the fork pin and of the switched load beyond the outputs.
// Assumes the bench clock; the fork stands still at 0 while damped.
`timescale 1ns/10ps
module fls_fork_load_model
(
   // Clock
   input wire logic i_mclk,
   // Bench commands
   input wire logic i_covered_cmd,
   input wire logic i_short_cmd,
   // Pins towards the device
   output logic o_fork_osc,
   output logic o_load_fault
);
   // Fork phase, starts low so the line is never unknown
   logic fork_phase = 1'b0;
   // Free fork swings fast, a covered fork is damped to a still line
   always @(posedge i_mclk)
   begin
      fork_phase <= i_covered_cmd ? 1'b0 : ~fork_phase;
   end
   assign o_fork_osc = fork_phase;
   // Short in the load wiring is reported as a level
   assign o_load_fault = i_short_cmd;
endmodule : fls_fork_load_model

// ===== testbench/tb.sv
// Self-checking bench for the fork level switch logic.
// Assumes shortened settle, flash and window counts set below.
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR %0t: got %0h want %0h", $time, a, e); end end
module tb;
   // Clock, reset and stimulus
   logic i_mclk = 1'b0, i_rst = 1'b1, i_magnet = 1'b0, i_sensor_fault = 1'b0;
   logic i_mode_dry = 1'b0, i_addr_wr = 1'b0, i_comm_err = 1'b0;
   logic [1:0] i_variant = 2'h0;
   logic [4:0] i_addr_val = 5'h00;
   logic [3:0] i_param_nibble = 4'h0;
   logic cov_cmd = 1'b0, short_cmd = 1'b0, i_fork_osc, i_load_fault;
   // Outputs
   logic o_switch_no, o_switch_nc, o_led_green, o_led_red, o_led_yellow;
   logic [3:0] o_data_nibble;
   logic [4:0] o_slave_addr;
   int num_errors = 0, num_checks = 0, n;
   always #2.5 i_mclk = ~i_mclk;
   // Design with short counts
   fls_top #(.COVER_CNT(28'h28), .FREE_CNT(28'h3C), .FLASH_CNT(28'h8), .WINDOW_CNT(28'hC8)) i_fls_top
   (.i_mclk(i_mclk), .i_rst(i_rst), .i_fork_osc(i_fork_osc), .i_magnet(i_magnet),
    .i_load_fault(i_load_fault), .i_sensor_fault(i_sensor_fault), .i_mode_dry(i_mode_dry),
    .i_variant(i_variant), .i_addr_wr(i_addr_wr), .i_addr_val(i_addr_val), .i_comm_err(i_comm_err),
    .i_param_nibble(i_param_nibble), .o_switch_no(o_switch_no), .o_switch_nc(o_switch_nc),
    .o_led_green(o_led_green), .o_led_red(o_led_red), .o_led_yellow(o_led_yellow),
    .o_data_nibble(o_data_nibble), .o_slave_addr(o_slave_addr));
   // Fork and load partner
   fls_fork_load_model i_fls_fork_load_model
   (.i_mclk(i_mclk), .i_covered_cmd(cov_cmd), .i_short_cmd(short_cmd),
    .o_fork_osc(i_fork_osc), .o_load_fault(i_load_fault));
   // Wait some clock edges
   task automatic cyc(input int k);
      repeat (k) @(posedge i_mclk);
   endtask : cyc
   // Wait for the covered bit under a bound, return the cycles taken
   task automatic wait_cov(input logic v);
      n = 0;
      while (o_data_nibble[0] !== v && n < 2000)
      begin
         @(posedge i_mclk);
         n++;
      end
      cyc(3);
   endtask : wait_cov
   // Count red changes over 32 cycles
   task automatic red_flips();
      logic last;
      n = 0;
      last = o_led_red;
      repeat (32)
      begin
         @(posedge i_mclk);
         if (o_led_red !== last) n++;
         last = o_led_red;
      end
   endtask : red_flips
   // Check both switches
   task automatic sw(input logic no, input logic nc);
      `CHK(o_switch_no, no)
      `CHK(o_switch_nc, nc)
   endtask : sw
   // One line per finished test
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask : done
   // Counts and verdict
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   // Watchdog
   initial
   begin
      #200000;
      num_errors++;
      print_verdict();
   end
   // Test sequence
   initial
   begin
      cyc(20);
      `CHK({o_switch_no, o_switch_nc, o_led_green, o_slave_addr}, 8'h00)
      i_rst <= 1'b0;
      cyc(4);
      `CHK(o_led_green, 1'b1)
      `CHK(o_slave_addr, 5'h00)
      done("reset");
      wait_cov(1'b0);
      sw(1'b1, 1'b0);
      `CHK({o_led_red, o_data_nibble}, 5'h02)
      cov_cmd <= 1'b1;
      wait_cov(1'b1);
      // Rest of the first window plus 40 settle cycles
      `CHK(n inside {[225:250]}, 1'b1)
      sw(1'b0, 1'b1);
      `CHK(o_led_red, 1'b1)
      `CHK(o_led_yellow, 1'b0)
      i_mode_dry <= 1'b1;
      cyc(4);
      sw(1'b1, 1'b0);
      `CHK(o_led_red, 1'b0)
      i_magnet <= 1'b1;
      cyc(4);
      sw(1'b0, 1'b1);
      i_magnet <= 1'b0;
      short_cmd <= 1'b1;
      cyc(4);
      sw(1'b0, 1'b0);
      red_flips();
      `CHK(n inside {3, 4}, 1'b1)
      short_cmd <= 1'b0;
      done("angle");
      i_variant <= 2'h1;
      i_sensor_fault <= 1'b1;
      cyc(4);
      sw(1'b0, 1'b0);
      `CHK(o_data_nibble[1], 1'b0)
      red_flips();
      `CHK(n inside {3, 4}, 1'b1)
      i_sensor_fault <= 1'b0;
      cyc(4);
      `CHK(o_led_yellow, 1'b1)
      `CHK(o_led_red, 1'b0)
      short_cmd <= 1'b1;
      cyc(4);
      red_flips();
      `CHK({o_led_red, n[3:0]}, 5'h10)
      short_cmd <= 1'b0;
      done("micro");
      i_variant <= 2'h3;
      i_param_nibble <= 4'hF;
      cyc(4);
      sw(1'b0, 1'b0);
      `CHK(o_led_red, 1'b1)
      i_addr_wr <= 1'b1;
      i_addr_val <= 5'h05;
      cyc(1);
      i_addr_wr <= 1'b0;
      cyc(2);
      `CHK(o_slave_addr, 5'h05)
      `CHK(o_led_red, 1'b0)
      i_comm_err <= 1'b1;
      cyc(3);
      `CHK(o_led_red, 1'b1)
      i_comm_err <= 1'b0;
      i_magnet <= 1'b1;
      cyc(4);
      `CHK(o_data_nibble, 4'h2)
      i_magnet <= 1'b0;
      cyc(4);
      `CHK(o_data_nibble, 4'h3)
      done("bus");
      cov_cmd <= 1'b0;
      wait_cov(1'b0);
      // One partly damped window, one full free window, then 60 settle cycles
      `CHK(n inside {[265:295]}, 1'b1)
      done("uncover");
      print_verdict();
   end
endmodule : tb
